// ===== rtl/spem_regs.vh
// Operation
// - five-entry log, oldest overwritten when full
// - newest entry first, oldest last
// - entries stamped hours minutes since reset
// - clear request empties log; reset too (an error in the clear cycle is kept as the only entry)
// - separate timer per CTS DSR RLSD
// - low until limit logs timeout error
// - timers disabled by default, limit zero
// - stop asserted yet data arrives logs no-halt
// - receive holding register overwrite logs overrun
// - bad or missing parity logs error
// - bad frame timing logs framing error
// - standard mode, no connection reports idle
// - server with connection reports in-use peer
// - client without connection reports unlocked
// - client holding connection reports locked
// - searching for peer reports scanning
// - refused connection reports disconnect
// - state snapshot refreshed only on reselect
// - revert command returns port standard mode
// - revert written straight to non-volatile store
`ifndef SPEM_REGS_VH
`define SPEM_REGS_VH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define SPEM_A_CTRL 8'h00
`define SPEM_A_CTS_LIM 8'h04
`define SPEM_A_DSR_LIM 8'h08
`define SPEM_A_RLSD_LIM 8'h0c
`define SPEM_A_CONN 8'h10
`define SPEM_A_PEER_ADDR 8'h14
`define SPEM_A_COUNT 8'h18
`define SPEM_A_UPTIME 8'h1c
`define SPEM_A_LOG0 8'h20
// ****************************************
// control fields
// ****************************************
`define SPEM_CTRL_CLEAR 0
`define SPEM_CTRL_REVERT 1
`define SPEM_CTRL_SNAP 2
// ****************************************
// error codes
// ****************************************
`define SPEM_E_CTS 3'h1
`define SPEM_E_DSR 3'h2
`define SPEM_E_RLSD 3'h3
`define SPEM_E_NOHALT 3'h4
`define SPEM_E_OVERRUN 3'h5
`define SPEM_E_PARITY 3'h6
`define SPEM_E_FRAME 3'h7
// ****************************************
// connection states and modes
// ****************************************
`define SPEM_S_FREE 3'h0
`define SPEM_S_INUSE 3'h1
`define SPEM_S_UNLOCK 3'h2
`define SPEM_S_LOCKED 3'h3
`define SPEM_S_SCAN 3'h4
`define SPEM_S_DISC 3'h5
`define SPEM_M_STANDARD 3'h0
// ****************************************
// resets and timing
// ****************************************
`define SPEM_LIM_RST 32'h0000_0000
`define SPEM_LOG_DEPTH 5
`define SPEM_CLK_NS 10
`define SPEM_MINUTE_S 60
// one minute of 10 ns cycles does not fit in 32 bits
`define SPEM_MIN_CYC 33'h1_65a0_bc00
`endif

// ===== rtl/spem_monitor.v
// Local design decisions: the AHB-Lite slave port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "spem_regs.vh"
module spem_monitor #(
  parameter [32:0] MIN_CYC = `SPEM_MIN_CYC
) (
  input wire CLOCK,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire CTS_IN,
  input wire DSR_IN,
  input wire RLSD_IN,
  input wire STOP_ACTIVE,
  input wire RX_CHAR_STB,
  input wire RX_OVERRUN,
  input wire RX_PARITY_ERR,
  input wire RX_FRAME_ERR,
  input wire [2:0] MODE,
  input wire IS_SERVER,
  input wire CONNECTED,
  input wire SCANNING,
  input wire REFUSED,
  input wire [15:0] PEER_PORT,
  input wire [31:0] PEER_ADDR,
  output reg NV_MODE_WE,
  output reg [2:0] NV_MODE_DATA
);
  // ****************************************
  // bus slave
  // ****************************************
  reg wr_pend_q;
  reg [7:0] addr_q;
  wire [95:0] lim_flat;
  reg [2:0] conn_state_q;
  reg [15:0] conn_port_q;
  reg [31:0] conn_addr_q;
  reg [2:0] cnt_q;
  reg [15:0] hours_q;
  reg [5:0] mins_q;
  reg [32:0] sub_q;
  wire [124:0] log_flat;
  reg [31:0] rdata_d;
  reg clr_req;
  reg rev_req;
  reg snap_req;
  wire addr_ok = HSEL && HREADY && HTRANS[1];
  integer i;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (HADDR[7:0])
      `SPEM_A_CTS_LIM: rdata_d = lim_flat[31:0];
      `SPEM_A_DSR_LIM: rdata_d = lim_flat[63:32];
      `SPEM_A_RLSD_LIM: rdata_d = lim_flat[95:64];
      `SPEM_A_CONN: rdata_d = {13'h0000, conn_state_q, conn_port_q};
      `SPEM_A_PEER_ADDR: rdata_d = conn_addr_q;
      `SPEM_A_COUNT: rdata_d = {29'h0000_0000, cnt_q};
      `SPEM_A_UPTIME: rdata_d = {10'h000, hours_q, mins_q};
      default: begin
        for (i = 0; i < 5; i = i + 1) begin
          if (HADDR[7:0] == `SPEM_A_LOG0 + 8'h04 * i[7:0]) begin
            rdata_d = {7'h00, log_flat[25*i +: 25]};
          end
        end
      end
    endcase
  end
  // writes land one cycle after the address phase; reads answer the same way
  always @(posedge CLOCK) begin
    if (RESET) begin
      wr_pend_q <= 1'b0;
      addr_q <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      wr_pend_q <= addr_ok && HWRITE;
      if (addr_ok) begin
        addr_q <= HADDR[7:0];
      end
      if (addr_ok && !HWRITE) begin
        HRDATA <= rdata_d;
      end
    end
  end
  always @* begin
    clr_req = wr_pend_q && addr_q == `SPEM_A_CTRL && HWDATA[`SPEM_CTRL_CLEAR];
    rev_req = wr_pend_q && addr_q == `SPEM_A_CTRL && HWDATA[`SPEM_CTRL_REVERT];
    snap_req = wr_pend_q && addr_q == `SPEM_A_CTRL && HWDATA[`SPEM_CTRL_SNAP];
  end
  // ****************************************
  // handshake timers
  // ****************************************
  wire [2:0] hs_in = {RLSD_IN, DSR_IN, CTS_IN};
  wire [2:0] hs_to;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_hs
      reg [31:0] lim_q;
      reg [31:0] tmr_q;
      reg fired_q;
      wire hit = !hs_in[g] && !fired_q && lim_q != `SPEM_LIM_RST && tmr_q + 32'h1 >= lim_q;
      assign hs_to[g] = hit;
      assign lim_flat[32*g +: 32] = lim_q;

      always @(posedge CLOCK) begin
        if (RESET) begin
          lim_q <= `SPEM_LIM_RST;
          tmr_q <= 32'h0000_0000;
          fired_q <= 1'b0;
        end else begin
          if (wr_pend_q && addr_q == `SPEM_A_CTS_LIM + 8'h04 * g) begin
            lim_q <= HWDATA;
          end
          if (hs_in[g]) begin
            tmr_q <= 32'h0000_0000;
            fired_q <= 1'b0;
          end else begin
            if (!fired_q) begin
              tmr_q <= tmr_q + 32'h1;
            end
            if (hit) begin
              fired_q <= 1'b1;
            end
          end
        end
      end
    end
  endgenerate
  // ****************************************
  // uptime since reset
  // ****************************************
  always @(posedge CLOCK) begin
    if (RESET) begin
      sub_q <= 33'h0_0000_0000;
      mins_q <= 6'h00;
      hours_q <= 16'h0000;
    end else if (sub_q == MIN_CYC - 33'h1) begin
      sub_q <= 33'h0_0000_0000;
      if (mins_q == 6'h3b) begin
        mins_q <= 6'h00;
        hours_q <= hours_q + 16'h1;
      end else begin
        mins_q <= mins_q + 6'h01;
      end
    end else begin
      sub_q <= sub_q + 33'h1;
    end
  end
  // ****************************************
  // error log
  // ****************************************
  // one entry per cycle; errors of the same cycle wait in pending flags until logged or dropped by a clear
  reg [7:1] raw_ev;
  reg [7:1] cand;
  reg [7:1] pend_q;
  reg [7:1] pend_d;
  reg [2:0] ev_code;
  integer k;

  always @* begin
    raw_ev = 7'h00;
    raw_ev[`SPEM_E_CTS] = hs_to[0];
    raw_ev[`SPEM_E_DSR] = hs_to[1];
    raw_ev[`SPEM_E_RLSD] = hs_to[2];
    raw_ev[`SPEM_E_NOHALT] = STOP_ACTIVE && RX_CHAR_STB;
    raw_ev[`SPEM_E_OVERRUN] = RX_OVERRUN;
    raw_ev[`SPEM_E_PARITY] = RX_PARITY_ERR;
    raw_ev[`SPEM_E_FRAME] = RX_FRAME_ERR;
    // a clear drops older pending errors but keeps those of its own cycle
    cand = clr_req ? raw_ev : (raw_ev | pend_q);
    ev_code = 3'h0;
    // highest code wins: frame first, cts last
    for (k = 1; k < 8; k = k + 1) begin
      if (cand[k]) begin
        ev_code = k[2:0];
      end
    end
    pend_d = cand;
    if (ev_code != 3'h0) begin
      // a fresh repeat of the error being logged stays pending
      pend_d[ev_code] = !clr_req && pend_q[ev_code] && raw_ev[ev_code];
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      pend_q <= 7'h00;
    end else begin
      pend_q <= pend_d;
    end
  end

  always @(posedge CLOCK) begin
    if (RESET) begin
      cnt_q <= 3'h0;
    end else if (ev_code != 3'h0) begin
      if (clr_req) begin
        cnt_q <= 3'h1;
      end else if (cnt_q != `SPEM_LOG_DEPTH) begin
        cnt_q <= cnt_q + 3'h1;
      end
    end else if (clr_req) begin
      cnt_q <= 3'h0;
    end
  end

  // shift chain: entry 0 newest, entry 4 falls off the end when full
  genvar e;
  generate
    for (e = 0; e < `SPEM_LOG_DEPTH; e = e + 1) begin : g_log
      reg [2:0] code_q;
      reg [21:0] time_q;
      wire [24:0] entry_in;
      assign log_flat[25*e +: 25] = {code_q, time_q};

      if (e == 0) begin : g_head
        assign entry_in = {ev_code, hours_q, mins_q};
      end else begin : g_tail
        // an event in the clear cycle survives as the only entry
        assign entry_in = clr_req ? 25'h000_0000 : log_flat[25*(e-1) +: 25];
      end

      always @(posedge CLOCK) begin
        if (RESET) begin
          code_q <= 3'h0;
          time_q <= 22'h000000;
        end else if (ev_code != 3'h0) begin
          code_q <= entry_in[24:22];
          time_q <= entry_in[21:0];
        end else if (clr_req) begin
          code_q <= 3'h0;
          time_q <= 22'h000000;
        end
      end
    end
  endgenerate

  // ****************************************
  // connection state snapshot and revert
  // ****************************************
  reg [2:0] live_state;
  always @* begin
    if (REFUSED) begin
      live_state = `SPEM_S_DISC;
    end else if (SCANNING) begin
      live_state = `SPEM_S_SCAN;
    end else if (MODE == `SPEM_M_STANDARD) begin
      live_state = (IS_SERVER && CONNECTED) ? `SPEM_S_INUSE : `SPEM_S_FREE;
    end else begin
      live_state = CONNECTED ? `SPEM_S_LOCKED : `SPEM_S_UNLOCK;
    end
  end
  always @(posedge CLOCK) begin
    if (RESET) begin
      conn_state_q <= `SPEM_S_FREE;
      conn_port_q <= 16'h0000;
      conn_addr_q <= 32'h0000_0000;
      NV_MODE_WE <= 1'b0;
      NV_MODE_DATA <= `SPEM_M_STANDARD;
    end else begin
      if (snap_req) begin
        conn_state_q <= live_state;
        conn_port_q <= PEER_PORT;
        conn_addr_q <= PEER_ADDR;
      end
      NV_MODE_WE <= rev_req;
      NV_MODE_DATA <= `SPEM_M_STANDARD;
    end
  end
endmodule // spem_monitor
`default_nettype wire

// ===== dv/spem_checker.sv
`timescale 1ns/10ps
`default_nettype none
`include "spem_regs.vh"
module spem_checker #(parameter [32:0] MIN_CYC = 100) (
  input wire CLOCK,
  input wire RESET,
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  input wire [31:0] HRDATA,
  input wire HREADYOUT,
  input wire HRESP,
  input wire NV_MODE_WE,
  input wire [2:0] NV_MODE_DATA
);
  wire ap = HSEL && HREADY && HTRANS[1];
  wire rd = ap && !HWRITE;
  wire [7:0] a = HADDR[7:0];
  logic wr_q = 0;
  logic rev_q = 0;
  // cleared in reset so no stale revert survives a mid-run reset
  always @(posedge CLOCK) begin
    wr_q <= !RESET && ap && HWRITE && a == `SPEM_A_CTRL;
    rev_q <= !RESET && wr_q && HWDATA[`SPEM_CTRL_REVERT];
  end
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  a_ready_okay: assert property (HREADYOUT && !HRESP) else $error("bus answer");
  a_revert_pulse: assert property (rev_q |-> ##[0:1] NV_MODE_WE) else $error("no revert");
  a_revert_cause: assert property (NV_MODE_WE |-> rev_q || $past(rev_q)) else $error("stray revert");
  a_pulse_single: assert property (NV_MODE_WE |=> !NV_MODE_WE) else $error("long revert");
  a_revert_mode: assert property (NV_MODE_WE |-> NV_MODE_DATA == `SPEM_M_STANDARD) else $error("mode");
  a_count_max: assert property (rd && a == `SPEM_A_COUNT |=> HRDATA <= 32'h5) else $error("count");
  a_unmapped_zero: assert property (rd && a > 8'h30 |=> HRDATA == 32'h0) else $error("unmapped");
  a_ctrl_zero: assert property (rd && a == `SPEM_A_CTRL |=> HRDATA == 32'h0) else $error("ctrl read");
  c_revert: cover property (NV_MODE_WE);
  c_write: cover property (wr_q);
  c_log: cover property (rd && a == `SPEM_A_LOG0);
endmodule // spem_checker
bind spem_monitor spem_checker #(.MIN_CYC(MIN_CYC)) chk (.CLOCK(CLOCK), .RESET(RESET), .HSEL(HSEL), .HADDR(HADDR),
  .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .NV_MODE_WE(NV_MODE_WE), .NV_MODE_DATA(NV_MODE_DATA));
`default_nettype wire

// ===== dv/spem_term.sv
`timescale 1ns/10ps
`default_nettype none
module spem_term (
  input wire clock,
  output logic [2:0] hs_n,
  output logic [3:0] ev
);
  // handshake lines idle high; error events are one-cycle pulses
  initial hs_n = 3'h7;
  initial ev = 4'h0;
  task drop(input int i, input int n);
    @(posedge clock) hs_n[i] <= 1'b0;
    repeat (n) @(posedge clock);
    hs_n[i] <= 1'b1;
  endtask
  task pulse(input int k);
    @(posedge clock) ev[k] <= 1'b1;
    @(posedge clock) ev[k] <= 1'b0;
  endtask
  // several error events in one cycle
  task burst(input logic [3:0] m);
    @(posedge clock) ev <= m;
    @(posedge clock) ev <= 4'h0;
  endtask
endmodule // spem_term
`default_nettype wire

// ===== dv/spem_monitor_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spem_regs.vh"
module spem_monitor_tb;
  localparam int MC = 100;
  logic clk = 0, rst = 1, sel = 0, wr = 0, stop = 0;
  logic [1:0] tr = 0;
  logic [2:0] mode = 0;
  logic [3:0] cs = 0;
  logic [15:0] port = 0;
  logic [31:0] adr = 0, wd = 0, pa = 0, d;
  wire [31:0] rdata;
  wire rdy, resp, nvwe;
  wire [2:0] hs, nvd;
  wire [3:0] ev;
  int mismatches = 0, comparisons = 0, cyc = 0, q[$];
  spem_term term (.clock(clk), .hs_n(hs), .ev(ev));
  spem_monitor #(.MIN_CYC(MC)) dut (.CLOCK(clk), .RESET(rst), .HSEL(sel), .HADDR(adr), .HTRANS(tr), .HWRITE(wr),
    .HSIZE(3'h2), .HWDATA(wd), .HREADY(rdy), .HRDATA(rdata), .HREADYOUT(rdy), .HRESP(resp), .CTS_IN(hs[0]),
    .DSR_IN(hs[1]), .RLSD_IN(hs[2]), .STOP_ACTIVE(stop), .RX_CHAR_STB(ev[0]), .RX_OVERRUN(ev[1]),
    .RX_PARITY_ERR(ev[2]), .RX_FRAME_ERR(ev[3]), .MODE(mode), .IS_SERVER(cs[0]), .CONNECTED(cs[1]),
    .SCANNING(cs[2]), .REFUSED(cs[3]), .PEER_PORT(port), .PEER_ADDR(pa), .NV_MODE_WE(nvwe), .NV_MODE_DATA(nvd));
  initial forever #5 clk = ~clk;
  always @(posedge clk) cyc <= rst ? 0 : cyc + 1;
  initial begin
    repeat (90000) @(posedge clk);
    mismatches++;
    stop_test;
  end
  task stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  task hold;
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rdy !== 1'b1 && i < 20);
    if (rdy !== 1'b1) begin
      mismatches++;
      stop_test;
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] v);
    sel <= 1;
    tr <= 2'h2;
    adr <= {24'h0, a};
    wr <= w;
    hold;
    sel <= 0;
    tr <= 2'h0;
    wd <= v;
    hold;
    d = rdata;
  endtask
  // keeps events clear of a minute boundary so stamps are exact
  task mid;
    while (cyc % MC < 5 || cyc % MC > 30) @(posedge clk);
  endtask
  task ex(input int c);
    int m;
    m = cyc / MC;
    q.push_front(c << 22 | m / 60 << 6 | m % 60);
    if (q.size() > 5) void'(q.pop_back());
  endtask
  task logchk;
    bus(`SPEM_A_COUNT, 0, 0);
    chk("count", 32'(q.size()), d);
    for (int i = 0; i < 5; i++) begin
      bus(8'(`SPEM_A_LOG0 + 4 * i), 0, 0);
      chk("entry", i < q.size() ? 32'(q[i]) : 32'h0, d);
    end
  endtask
  initial begin
    int lim;
    logic [3:0] tc[6] = '{4'h0, 4'h3, 4'h0, 4'h2, 4'h4, 4'hc};
    void'($urandom(32'hcbd45862));
    repeat (10) @(posedge clk);
    rst <= 0;
    bus(8'h40, 0, 0);
    chk("unmapped", 0, d);
    logchk;
    term.drop(0, 40);
    logchk;
    for (int i = 0; i < 3; i++) begin
      lim = 8 + $urandom % 16;
      bus(8'(`SPEM_A_CTS_LIM + 4 * i), 0, 0);
      chk("limit reset", 0, d);
      bus(8'(`SPEM_A_CTS_LIM + 4 * i), 1, lim);
      bus(8'(`SPEM_A_CTS_LIM + 4 * i), 0, 0);
      chk("limit", lim, d);
      term.drop(i, lim - 3);
      term.drop(i, lim - 3);
      mid;
      term.drop(i, lim + 12);
      ex(i + 1);
    end
    logchk;
    mid;
    stop <= 1;
    for (int k = 0; k < 4; k++) begin
      term.pulse(k);
      ex(4 + k);
    end
    term.burst(4'h6);
    ex(6);
    ex(5);
    stop <= 0;
    term.pulse(0);
    logchk;
    bus(`SPEM_A_CTRL, 1, 32'h1);
    q.delete();
    logchk;
    for (int s = 0; s < 6; s++) begin
      mode <= s > 1 ? 3'(1 + $urandom % 6) : 3'h0;
      cs <= tc[s];
      port <= 16'($urandom);
      pa <= $urandom;
      bus(`SPEM_A_CONN, 0, 0);
      chk("held state", 32'(s > 0 ? s - 1 : 0), {29'h0, d[18:16]});
      bus(`SPEM_A_CTRL, 1, 32'h4);
      bus(`SPEM_A_CONN, 0, 0);
      chk("state", 32'(s), {29'h0, d[18:16]});
      if (s == 1) chk("in use", {13'h0, 3'h1, port}, d);
      bus(`SPEM_A_PEER_ADDR, 0, 0);
      if (s == 1) chk("peer", pa, d);
    end
    bus(`SPEM_A_CTRL, 1, 32'h2);
    lim = 0;
    repeat (3) begin
      @(posedge clk);
      if (nvwe === 1'b1) lim++;
    end
    chk("revert pulses", 1, lim);
    chk("revert mode", 32'(`SPEM_M_STANDARD), {29'h0, nvd});
    stop_test;
  end
endmodule // spem_monitor_tb
`default_nettype wire
